// ==== design/asc_map.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH
`define ASC_CTRL_OFS 8'h00
`define ASC_GEN0_OFS 8'h04
`define ASC_GEN1_OFS 8'h08
`define ASC_CHDIV_OFS 8'h0C
`define ASC_STAT_OFS 8'h10
`define ASC_FILL_OFS 8'h14
`define ASC_THR_OFS 8'h18
`define ASC_DATA_OFS 8'h1C
`define ASC_IRQEN_OFS 8'h20
`define ASC_DMAADR_OFS 8'h24
`define ASC_DMACNT_OFS 8'h28
`define ASC_SSYNC_LSB 16
`define ASC_ST_DONE_LSB 0
`define ASC_ST_THR 2
`define ASC_ST_DMA 3
`define ASC_ST_BUSY_LSB 4
`define ASC_CTRL_RST 16'h0000
`define ASC_GEN_MIN 24'h7AE147
`define ASC_GEN_MAX 24'hF5C28F
`define ASC_DIV_RST 30'h0210_8421
`define ASC_DIV_MIN 5'h01
`define ASC_DIV_MAX 5'h14
`define ASC_THR_RST 16'h8000
`define ASC_THR_MAX 16'hFFFE
`define ASC_PRE16 6'h1F
`define ASC_PRE32 6'h3F
`define ASC_FIFO_DEPTH 65536
`define ASC_SETTLE_MS 20
`define ASC_CLK_KHZ 40000
`endif

// ==== design/asc_pkg.sv ====
// Types shared by the acquisition control core
package asc_pkg;
  typedef enum logic [1:0] {SRC_GEN0 = 2'b00, SRC_GEN1 = 2'b01, SRC_EXT = 2'b10} asc_src_t;
  typedef struct packed {
    logic [5:0] ext_ch;
    logic [1:0] hsync;
    asc_src_t cko_src;
    asc_src_t g1_src;
    asc_src_t g0_src;
    logic osr;
    logic fmt;
  } asc_ctrl_t;
  typedef struct packed {
    logic [2:0] tag;
    logic [15:0] value;
  } asc_sample_t;
  typedef enum logic [1:0] {DMA_IDLE = 2'b00, DMA_LOAD = 2'b01, DMA_WRITE = 2'b10} asc_dma_st_t;
endpackage

// ==== design/asc_chan.sv ====
// One channel's timing: oversampling prescaler and integer rate divider
`timescale 1ns/1ps
`include "asc_map.svh"

module asc_chan (
  input wire logic ref_clk, // Core clock
  input wire logic reset, // Async reset, high
  input wire logic src_tick, // Rate source tick
  input wire logic osr, // High selects divide by 64
  input wire logic sync, // Restart pulse
  input wire logic [4:0] div, // Raw divisor
  output logic strobe // Sample moment
);
  logic [5:0] pre_reg;
  logic [4:0] cnt_reg;
  logic pre_tick;
  logic [4:0] lim;

  // Out-of-range divisors are pinned so the counter can never run away
  function automatic logic [4:0] clamp_div(input logic [4:0] d);
    if (d < `ASC_DIV_MIN) begin
      return `ASC_DIV_MIN;
    end
    return (d > `ASC_DIV_MAX) ? `ASC_DIV_MAX : d;
  endfunction

  assign lim = clamp_div(div);
  assign pre_tick = src_tick && (pre_reg == (osr ? `ASC_PRE32 : `ASC_PRE16));
  assign strobe = pre_tick && (cnt_reg >= lim - 5'h01);

  // Prescaler; sync restarts it so all channels of a group line up
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pre_reg <= 6'h00;
    end else if (sync) begin
      pre_reg <= 6'h00;
    end else if (src_tick) begin
      pre_reg <= pre_tick ? 6'h00 : pre_reg + 6'h01;
    end
  end

  // Rate divider, also restarted by sync
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= 5'h00;
    end else if (sync) begin
      cnt_reg <= 5'h00;
    end else if (pre_tick) begin
      cnt_reg <= strobe ? 5'h00 : cnt_reg + 5'h01;
    end
  end

  property p_gap;
    @(posedge ref_clk) disable iff (reset) strobe |=> !strobe [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("strobes closer than prescale");

  property p_sync;
    @(posedge ref_clk) disable iff (reset) sync |=> !strobe;
  endproperty
  a_sync: assert property (p_sync) else $error("strobe right after sync");
endmodule // asc_chan

// ==== design/asc_top.sv ====
// Acquisition control core: rate generators, channel timing, tagged sample FIFO, DMA
`timescale 1ns/1ps
`include "asc_map.svh"

module asc_top
  import asc_pkg::*;
#(
  parameter int DEPTH = `ASC_FIFO_DEPTH, // Buffer entries
  parameter int SETTLE_CYCLES = `ASC_SETTLE_MS * `ASC_CLK_KHZ // Settle wait, clocks
) (
  input wire logic ref_clk, // Core clock, 40 MHz
  input wire logic reset, // Async reset, high
  input wire logic [7:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [3:0] avs_byteenable, // Byte lanes
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  output logic [31:0] dma_address, // DMA byte address
  output logic dma_write, // DMA write request
  output logic [31:0] dma_writedata, // DMA word
  input wire logic dma_waitrequest, // DMA stall
  input wire logic [95:0] adc_result, // Six offset-binary results
  input wire logic clk_in, // External clock pin
  input wire logic sync_in, // External sync pin
  output logic clk_out, // Chain clock out
  output logic sync_out, // Chain sync out
  output logic irq // Shared interrupt
);
  localparam int AW = $clog2(DEPTH);
  localparam int SW = $clog2(SETTLE_CYCLES + 1);

  asc_ctrl_t ctrl_reg;
  logic [23:0] gen_inc_reg [2];
  logic [23:0] gen_acc_reg [2];
  logic [1:0] gen_tick_reg;
  logic [1:0] gen_half_reg;
  logic [SW-1:0] settle_cnt_reg [2];
  logic [1:0] settle_done_reg;
  logic [29:0] div_reg;
  logic [15:0] thr_reg;
  logic [2:0] irqen_reg;
  logic [31:0] dma_base_reg;
  logic [31:0] dma_cnt_reg;
  asc_dma_st_t dma_st_reg;
  logic [1:0] soft_sync_reg;
  logic [2:0] clk_sy_reg;
  logic [2:0] sync_sy_reg;
  logic [5:0] pend_reg;
  asc_sample_t pend_data_reg [6];
  asc_sample_t mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] fill_reg;
  logic thr_flag_reg;
  logic rd_pop_reg;
  logic ext_tick;
  logic hw_sync;
  logic [1:0] grp_sync;
  logic [5:0] ch_src;
  logic [5:0] ch_strobe;
  logic [2:0] pick;
  logic push;
  logic pop;
  logic cpu_pop;
  logic dma_pop;
  logic acc_go;
  logic wr_en;
  logic fifo_has;

  // Tick of the source a channel group has chosen
  function automatic logic src_of(input asc_src_t sel, input logic [1:0] gt, input logic et);
    case (sel)
      SRC_GEN0: return gt[0];
      SRC_GEN1: return gt[1];
      default: return et;
    endcase
  endfunction

  // Bus handshake: first cycle of a request, and a full-word write at completion
  assign acc_go = (avs_read || avs_write) && avs_waitrequest;
  assign wr_en = avs_write && !avs_waitrequest && (avs_byteenable == 4'hF);
  assign fifo_has = (fill_reg != '0);

  // Pins are asynchronous; the first flop is read only by the second
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      clk_sy_reg <= 3'h0;
      sync_sy_reg <= 3'h0;
    end else begin
      clk_sy_reg <= {clk_sy_reg[1:0], clk_in};
      sync_sy_reg <= {sync_sy_reg[1:0], sync_in};
    end
  end

  assign ext_tick = clk_sy_reg[1] && !clk_sy_reg[2];
  assign hw_sync = sync_sy_reg[1] && !sync_sy_reg[2];

  // A group restarts on its software pulse or, if enabled, on the sync pin
  assign grp_sync[0] = soft_sync_reg[0] || (ctrl_reg.hsync[0] && hw_sync);
  assign grp_sync[1] = soft_sync_reg[1] || (ctrl_reg.hsync[1] && hw_sync);

  // Control registers written by software
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= asc_ctrl_t'(`ASC_CTRL_RST);
      soft_sync_reg <= 2'h0;
      div_reg <= `ASC_DIV_RST;
      thr_reg <= `ASC_THR_RST;
      irqen_reg <= 3'h0;
      dma_base_reg <= 32'h0000_0000;
    end else begin
      soft_sync_reg <= 2'h0;
      if (wr_en) begin
        case (avs_address)
          `ASC_CTRL_OFS: begin
            ctrl_reg <= asc_ctrl_t'(avs_writedata[15:0]);
            soft_sync_reg <= avs_writedata[`ASC_SSYNC_LSB +: 2];
          end
          `ASC_CHDIV_OFS: div_reg <= avs_writedata[29:0];
          `ASC_THR_OFS: begin
            // Clamp keeps the flag reachable below a full buffer
            thr_reg <= (avs_writedata[15:0] > `ASC_THR_MAX) ? `ASC_THR_MAX
                       : avs_writedata[15:0];
          end
          `ASC_IRQEN_OFS: irqen_reg <= avs_writedata[2:0];
          `ASC_DMAADR_OFS: dma_base_reg <= avs_writedata;
          default: ;
        endcase
      end
    end
  end

  // Generator settings and settle timers; a done flag is set before it is cleared
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int g = 0; g < 2; g++) begin
        gen_inc_reg[g] <= `ASC_GEN_MIN;
        settle_cnt_reg[g] <= '0;
      end
      settle_done_reg <= 2'h0;
    end else begin
      for (int g = 0; g < 2; g++) begin
        if (wr_en && avs_address == (g == 0 ? `ASC_GEN0_OFS : `ASC_GEN1_OFS)) begin
          if (avs_writedata[23:0] < `ASC_GEN_MIN) begin
            gen_inc_reg[g] <= `ASC_GEN_MIN;
          end else if (avs_writedata[23:0] > `ASC_GEN_MAX) begin
            gen_inc_reg[g] <= `ASC_GEN_MAX;
          end else begin
            gen_inc_reg[g] <= avs_writedata[23:0];
          end
          settle_cnt_reg[g] <= SW'(SETTLE_CYCLES);
          settle_done_reg[g] <= 1'b0;
        end else if (settle_cnt_reg[g] != '0) begin
          settle_cnt_reg[g] <= settle_cnt_reg[g] - 1'b1;
          if (settle_cnt_reg[g] == SW'(1)) begin
            settle_done_reg[g] <= 1'b1;
          end
        end else if (wr_en && avs_address == `ASC_STAT_OFS
                     && avs_writedata[`ASC_ST_DONE_LSB + g]) begin
          settle_done_reg[g] <= 1'b0;
        end
      end
    end
  end

  // Phase accumulators; carry rate is inc/2^24 of the core clock
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int g = 0; g < 2; g++) begin
        gen_acc_reg[g] <= 24'h000000;
      end
      gen_tick_reg <= 2'h0;
      gen_half_reg <= 2'h0;
    end else begin
      for (int g = 0; g < 2; g++) begin
        {gen_tick_reg[g], gen_acc_reg[g]} <= {1'b0, gen_acc_reg[g]}
                                             + {1'b0, gen_inc_reg[g]};
        if (gen_tick_reg[g]) begin
          gen_half_reg[g] <= ~gen_half_reg[g];
        end
      end
    end
  end

  // Six channel timers; group is channel/3, external clock may override
  generate
    for (genvar c = 0; c < 6; c++) begin : g_ch
      localparam int GRP = c / 3;
      assign ch_src[c] = ctrl_reg.ext_ch[c] ? ext_tick
                       : src_of(GRP == 0 ? ctrl_reg.g0_src : ctrl_reg.g1_src,
                                gen_tick_reg, ext_tick);
      asc_chan u_chan (
        .ref_clk(ref_clk),
        .reset(reset),
        .src_tick(ch_src[c]),
        .osr(ctrl_reg.osr),
        .sync(grp_sync[GRP]),
        .div(div_reg[5*c +: 5]),
        .strobe(ch_strobe[c])
      );
    end
  endgenerate

  // Lowest pending channel goes into the buffer first
  always_comb begin
    pick = 3'h0;
    for (int c = 5; c >= 0; c--) begin
      if (pend_reg[c]) begin
        pick = 3'(c);
      end
    end
  end

  // A full buffer holds samples in the pending slots; a new strobe overwrites
  assign push = (|pend_reg) && (fill_reg != (AW + 1)'(DEPTH));
  assign cpu_pop = avs_read && !avs_waitrequest && rd_pop_reg;
  assign dma_pop = (dma_st_reg == DMA_LOAD) && fifo_has;
  assign pop = cpu_pop || dma_pop;

  // Capture results with tag and format; new strobe wins over the drain
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pend_reg <= 6'h00;
      for (int c = 0; c < 6; c++) begin
        pend_data_reg[c] <= '0;
      end
    end else begin
      for (int c = 0; c < 6; c++) begin
        if (ch_strobe[c]) begin
          pend_reg[c] <= 1'b1;
          pend_data_reg[c].tag <= 3'(c);
          pend_data_reg[c].value <= ctrl_reg.fmt
            ? {~adc_result[16*c + 15], adc_result[16*c +: 15]}
            : adc_result[16*c +: 16];
        end else if (push && pick == 3'(c)) begin
          pend_reg[c] <= 1'b0;
        end
      end
    end
  end

  // Sample storage
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= pend_data_reg[pick];
    end
  end

  // Pointers and fill count
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      fill_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      case ({push, pop})
        2'b10: fill_reg <= fill_reg + 1'b1;
        2'b01: fill_reg <= fill_reg - 1'b1;
        default: ;
      endcase
    end
  end

  // Threshold flag and the shared interrupt line, both from flops
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      thr_flag_reg <= 1'b0;
      irq <= 1'b0;
    end else begin
      // Full-width compare so a shallow buffer does not fold the threshold
      thr_flag_reg <= (32'(fill_reg) >= 32'(thr_reg));
      irq <= |(irqen_reg & {thr_flag_reg, settle_done_reg});
    end
  end

  // Daisy-chain outputs; the 40 MHz sampler limits how fast a clock can pass
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      clk_out <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      case (ctrl_reg.cko_src)
        SRC_GEN0: clk_out <= gen_half_reg[0];
        SRC_GEN1: clk_out <= gen_half_reg[1];
        default: clk_out <= clk_sy_reg[1];
      endcase
      sync_out <= |grp_sync;
    end
  end

  // Bus slave: one wait cycle, data sampled at the first request cycle
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      rd_pop_reg <= 1'b0;
    end else begin
      avs_waitrequest <= !acc_go;
      if (acc_go && avs_read) begin
        // A data read pops only if the buffer is not being drained by DMA
        rd_pop_reg <= (avs_address == `ASC_DATA_OFS) && (dma_st_reg == DMA_IDLE) && fifo_has;
        case (avs_address)
          `ASC_CTRL_OFS: avs_readdata <= {16'h0000, ctrl_reg};
          `ASC_GEN0_OFS: avs_readdata <= {8'h00, gen_inc_reg[0]};
          `ASC_GEN1_OFS: avs_readdata <= {8'h00, gen_inc_reg[1]};
          `ASC_CHDIV_OFS: avs_readdata <= {2'h0, div_reg};
          `ASC_STAT_OFS: avs_readdata <= {26'h0, settle_cnt_reg[1] != '0,
                                          settle_cnt_reg[0] != '0, dma_st_reg != DMA_IDLE,
                                          thr_flag_reg, settle_done_reg};
          `ASC_FILL_OFS: avs_readdata <= 32'(fill_reg);
          `ASC_THR_OFS: avs_readdata <= {16'h0000, thr_reg};
          `ASC_DATA_OFS: avs_readdata <= ((dma_st_reg == DMA_IDLE) && fifo_has)
                                         ? 32'(mem[rd_ptr_reg]) : 32'h0000_0000;
          `ASC_IRQEN_OFS: avs_readdata <= {29'h0, irqen_reg};
          `ASC_DMAADR_OFS: avs_readdata <= dma_base_reg;
          `ASC_DMACNT_OFS: avs_readdata <= dma_cnt_reg;
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // DMA master: one sample per word, walks upward from the base address
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dma_st_reg <= DMA_IDLE;
      dma_cnt_reg <= 32'h0000_0000;
      dma_address <= 32'h0000_0000;
      dma_write <= 1'b0;
      dma_writedata <= 32'h0000_0000;
    end else begin
      case (dma_st_reg)
        DMA_IDLE: begin
          if (wr_en && avs_address == `ASC_DMACNT_OFS && avs_writedata != 32'h0) begin
            dma_cnt_reg <= avs_writedata;
            dma_address <= dma_base_reg;
            dma_st_reg <= DMA_LOAD;
          end
        end
        DMA_LOAD: begin
          if (fifo_has) begin
            dma_writedata <= 32'(mem[rd_ptr_reg]);
            dma_write <= 1'b1;
            dma_st_reg <= DMA_WRITE;
          end
        end
        DMA_WRITE: begin
          if (!dma_waitrequest) begin
            dma_write <= 1'b0;
            dma_address <= dma_address + 32'h0000_0004;
            dma_cnt_reg <= dma_cnt_reg - 32'h0000_0001;
            dma_st_reg <= (dma_cnt_reg == 32'h0000_0001) ? DMA_IDLE : DMA_LOAD;
          end
        end
        default: dma_st_reg <= DMA_IDLE;
      endcase
    end
  end

  property p_thr;
    @(posedge ref_clk) disable iff (reset)
      (32'(fill_reg) >= 32'(thr_reg)) |=> thr_flag_reg;
  endproperty
  a_thr: assert property (p_thr) else $error("threshold flag missing");

  property p_thr_max;
    @(posedge ref_clk) disable iff (reset) thr_reg <= `ASC_THR_MAX;
  endproperty
  a_thr_max: assert property (p_thr_max) else $error("threshold above limit");

  property p_fill_up;
    @(posedge ref_clk) disable iff (reset)
      (push && !pop) |=> (fill_reg == $past(fill_reg) + 1'b1);
  endproperty
  a_fill_up: assert property (p_fill_up) else $error("count not incremented");

  property p_fill_dn;
    @(posedge ref_clk) disable iff (reset)
      (pop && !push) |=> (fill_reg == $past(fill_reg) - 1'b1) && (rd_ptr_reg != $past(rd_ptr_reg));
  endproperty
  a_fill_dn: assert property (p_fill_dn) else $error("count not decremented");

  property p_irq;
    @(posedge ref_clk) disable iff (reset)
      (thr_flag_reg && irqen_reg[2]) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("threshold interrupt missing");

  property p_gen;
    @(posedge ref_clk) disable iff (reset)
      gen_inc_reg[0] >= `ASC_GEN_MIN && gen_inc_reg[0] <= `ASC_GEN_MAX
        && gen_inc_reg[1] >= `ASC_GEN_MIN && gen_inc_reg[1] <= `ASC_GEN_MAX;
  endproperty
  a_gen: assert property (p_gen) else $error("generator out of span");

  property p_settle;
    @(posedge ref_clk) disable iff (reset)
      (settle_cnt_reg[0] == SW'(1)) |=> settle_done_reg[0] ##1 settle_done_reg[0];
  endproperty
  a_settle: assert property (p_settle) else $error("settle done not set");

  property p_ack;
    @(posedge ref_clk) disable iff (reset)
      acc_go |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer timing wrong");

  property p_dma;
    @(posedge ref_clk) disable iff (reset)
      (dma_write && dma_waitrequest) |=> dma_write && $stable(dma_address)
                                           && $stable(dma_writedata);
  endproperty
  a_dma: assert property (p_dma) else $error("dma request dropped");
endmodule // asc_top

// ==== dv/asc_host_mem.sv ====
// Host memory model that takes the core's DMA words
`timescale 1ns/1ps
module asc_host_mem (
  input wire logic ref_clk, // Core clock
  input wire logic reset, // Async reset, high
  input wire logic slow, // Adds stall cycles
  input wire logic [31:0] dma_address, // Byte address
  input wire logic dma_write, // Write request
  input wire logic [31:0] dma_writedata, // Word
  output logic dma_waitrequest // Stall
);
  logic [31:0] mem [8];
  logic [31:0] adr [8];
  logic [1:0] gap;
  int n;
  // Stall a while, then take one word; slow mode makes the core hold its request
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dma_waitrequest <= 1'b1;
      gap <= 2'h0;
      n <= 0;
    end else if (dma_write && dma_waitrequest && gap == (slow ? 2'h3 : 2'h0)) begin
      dma_waitrequest <= 1'b0;
      mem[n[2:0]] <= dma_writedata;
      adr[n[2:0]] <= dma_address;
      n <= n + 1;
      gap <= 2'h0;
    end else begin
      dma_waitrequest <= 1'b1;
      gap <= (dma_write && dma_waitrequest) ? gap + 2'h1 : 2'h0;
    end
  end
endmodule // asc_host_mem

// ==== dv/testbench.sv ====
// Self-checking bench for the acquisition control core
`timescale 1ns/1ps
`include "asc_map.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, e); end end
module testbench;
  import asc_pkg::*;
  logic ref_clk, reset, avs_read, avs_write, avs_waitrequest, dma_write, dma_waitrequest;
  logic clk_in, sync_in, clk_out, sync_out, irq, slow;
  logic [7:0] avs_address;
  logic [3:0] be;
  logic [31:0] avs_writedata, avs_readdata, dma_address, dma_writedata, rd;
  logic [95:0] adc_result;
  int failures = 0;
  int checked = 0;
  int clk_rises = 0;
  int syncs = 0;
  asc_top #(.DEPTH(16), .SETTLE_CYCLES(50)) asc_top_inst (.ref_clk(ref_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(be), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dma_address(dma_address), .dma_write(dma_write),
    .dma_writedata(dma_writedata), .dma_waitrequest(dma_waitrequest),
    .adc_result(adc_result), .clk_in(clk_in), .sync_in(sync_in), .clk_out(clk_out),
    .sync_out(sync_out), .irq(irq));
  asc_host_mem asc_host_mem_inst (.ref_clk(ref_clk), .reset(reset), .slow(slow),
    .dma_address(dma_address), .dma_write(dma_write), .dma_writedata(dma_writedata),
    .dma_waitrequest(dma_waitrequest));
  // 40 MHz core clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Chain outputs counted so tests can judge them later
  always @(posedge ref_clk) if (sync_out === 1'b1) syncs++;
  always @(posedge clk_out) clk_rises++;
  function automatic logic [15:0] val(input int c);
    return 16'h1111 * 16'(c + 1);
  endfunction
  task automatic give_verdict;
    $display("checks=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One register access; held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge ref_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) failures++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  // Three rounds, since full-buffer pending slots refill as space frees
  task automatic drain;
    repeat (3) begin
      bus(1'b0, `ASC_FILL_OFS, 32'h0);
      repeat (int'(rd[16:0])) bus(1'b0, `ASC_DATA_OFS, 32'h0);
    end
  endtask
  task automatic cfg(input logic [31:0] c);
    bus(1'b1, `ASC_CTRL_OFS, c | 32'h0003_0000);
    drain();
  endtask
  // External clock edges at 200 ns, then time for samples to land
  task automatic ext(input int n);
    repeat (n) begin
      repeat (4) @(posedge ref_clk);
      clk_in <= 1'b1;
      repeat (4) @(posedge ref_clk);
      clk_in <= 1'b0;
    end
    repeat (30) @(posedge ref_clk);
  endtask
  task automatic pulse_sync;
    sync_in <= 1'b1;
    repeat (8) @(posedge ref_clk);
    sync_in <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic t_reset;
    chk_rd(`ASC_GEN0_OFS, 32'h007A_E147);
    chk_rd(`ASC_CHDIV_OFS, 32'h0210_8421);
    chk_rd(`ASC_THR_OFS, 32'h0000_8000);
    chk_rd(8'h40, 32'h0);
    bus(1'b1, `ASC_GEN0_OFS, 32'h0);
    chk_rd(`ASC_GEN0_OFS, 32'h007A_E147);
    bus(1'b1, `ASC_GEN0_OFS, 32'h00FF_FFFF);
    chk_rd(`ASC_GEN0_OFS, 32'h00F5_C28F);
    be <= 4'h3;
    bus(1'b1, `ASC_THR_OFS, 32'h1);
    be <= 4'hF;
    chk_rd(`ASC_THR_OFS, 32'h0000_8000);
    bus(1'b1, `ASC_THR_OFS, 32'hFFFF);
    chk_rd(`ASC_THR_OFS, 32'h0000_FFFE);
  endtask
  task automatic t_settle;
    bus(1'b1, `ASC_IRQEN_OFS, 32'h2);
    bus(1'b1, `ASC_GEN1_OFS, 32'h0080_0000);
    bus(1'b0, `ASC_STAT_OFS, 32'h0);
    `CHK(rd[5], 1'b1)
    `CHK(rd[1], 1'b0)
    repeat (60) @(posedge ref_clk);
    bus(1'b0, `ASC_STAT_OFS, 32'h0);
    `CHK(rd[1], 1'b1)
    `CHK(irq, 1'b1)
    bus(1'b1, `ASC_STAT_OFS, 32'h3);
    bus(1'b0, `ASC_STAT_OFS, 32'h0);
    `CHK(irq, 1'b0)
    bus(1'b1, `ASC_IRQEN_OFS, 32'h4);
  endtask
  task automatic t_buffer;
    syncs = 0;
    cfg(32'hA8);
    bus(1'b1, `ASC_THR_OFS, 32'h6);
    clk_rises = 0;
    ext(32);
    chk_rd(`ASC_FILL_OFS, 32'h6);
    bus(1'b0, `ASC_STAT_OFS, 32'h0);
    `CHK(rd[2], 1'b1)
    `CHK(irq, 1'b1)
    bus(1'b1, `ASC_THR_OFS, 32'h7);
    bus(1'b0, `ASC_STAT_OFS, 32'h0);
    `CHK(rd[2], 1'b0)
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, `ASC_DATA_OFS, 32'h0);
      `CHK(rd, {13'h0, 3'(i), val(i)})
      chk_rd(`ASC_FILL_OFS, 32'(5 - i));
    end
    chk_rd(`ASC_DATA_OFS, 32'h0);
    `CHK(clk_rises, 32)
    `CHK(syncs > 0, 1'b1)
    bus(1'b1, `ASC_THR_OFS, 32'h0);
    bus(1'b0, `ASC_STAT_OFS, 32'h0);
    `CHK(rd[2], 1'b1)
    // Threshold of one turns the flag into a not-empty indication
    bus(1'b1, `ASC_THR_OFS, 32'h1);
    bus(1'b0, `ASC_STAT_OFS, 32'h0);
    `CHK(rd[2], 1'b0)
  endtask
  task automatic t_rate;
    cfg(32'hAA);
    ext(64);
    chk_rd(`ASC_FILL_OFS, 32'h6);
    bus(1'b1, `ASC_CHDIV_OFS, 32'h0210_8422);
    cfg(32'hA8);
    ext(64);
    chk_rd(`ASC_FILL_OFS, 32'd11);
    bus(1'b1, `ASC_CHDIV_OFS, 32'h0210_8421);
    // Group 1 on generator 1, channel 3 forced onto the idle external clock
    cfg(32'h2098);
    repeat (300) @(posedge ref_clk);
    bus(1'b0, `ASC_DATA_OFS, 32'h0);
    `CHK(rd[18:16], 3'h4)
  endtask
  task automatic t_dma;
    cfg(32'hA9);
    slow <= 1'b1;
    ext(32);
    bus(1'b1, `ASC_DMAADR_OFS, 32'h100);
    bus(1'b1, `ASC_DMACNT_OFS, 32'h6);
    repeat (20) begin
      bus(1'b0, `ASC_STAT_OFS, 32'h0);
      if (rd[3] === 1'b0) break;
    end
    `CHK(rd[3], 1'b0)
    `CHK(asc_host_mem_inst.n, 6)
    for (int i = 0; i < 6; i++) begin
      `CHK(asc_host_mem_inst.mem[i], {13'h0, 3'(i), val(i) ^ 16'h8000})
      `CHK(asc_host_mem_inst.adr[i], 32'h100 + 32'(4 * i))
    end
    chk_rd(`ASC_FILL_OFS, 32'h0);
  endtask
  task automatic t_sync;
    bus(1'b1, `ASC_CTRL_OFS, 32'hA8);
    syncs = 0;
    pulse_sync();
    `CHK(syncs, 0)
    bus(1'b1, `ASC_CTRL_OFS, 32'h3A8);
    pulse_sync();
    `CHK(syncs, 1)
  endtask
  // Reset, then the scenarios in turn
  initial begin
    {avs_read, avs_write, clk_in, sync_in, slow} = '0;
    avs_address = '0;
    avs_writedata = '0;
    be = 4'hF;
    reset = 1'b1;
    for (int c = 0; c < 6; c++) adc_result[16*c +: 16] = val(c);
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_settle();
    t_buffer();
    t_rate();
    t_dma();
    t_sync();
    give_verdict();
  end
  // Hang guard, well past the few thousand cycles the tests need
  initial begin
    #500000;
    failures++;
    give_verdict();
  end
endmodule // testbench
